// File: inc/irq_ctl_pkg.sv
/*
  shared constants, types and helpers of the nested interrupt controller.
  assumes an apb register slave with 32-bit data and a core that reports
  instruction completion events on the same clock.
*/
package irq_ctl_pkg;
  localparam int NVEC = 13;
  localparam int NEXT = 3;
  localparam int EXT_PINS = 4;
  localparam int EXT_BASE = 2;
  localparam int CC_HI_POS = 5;
  localparam int CC_LO_POS = 3;
  // level codes as held in the two current-level bits {high, low}
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;
  localparam logic [1:0] PRIO_RST = 2'h3;
  localparam logic [5:0] PRIO_PAD = 6'h3f;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_BASE = 16'hfffa;
  localparam logic [15:0] VEC_BOTTOM = 16'hffe0;
  // vectors able to end halt: 0, 2, 3, 4, 10
  localparam logic [NVEC-1:0] HALT_WAKE = 13'h041d;
  localparam logic [11:0] ADDR_PRIO_BASE = 12'h000;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h010;
  localparam logic [11:0] ADDR_EXT_SEL = 12'h014;
  localparam logic [11:0] ADDR_EXT_EDGE = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01c;
  localparam logic [NVEC-1:0] IRQ_EN_RST = 13'h0000;
  localparam logic [11:0] EXT_SEL_RST = 12'h000;
  localparam logic [2:0] EXT_EDGE_RST = 3'h0;

  typedef enum logic [2:0] {ST_RUN, ST_STACK, ST_VECTOR, ST_WAIT, ST_HALT} ctl_state_type;

  typedef struct packed {
    logic instr_end;
    logic trap;
    logic interrupt_return_instr;
    logic irq_enable_instr;
    logic sim;
    logic halt;
    logic wait_for_irq_instr;
    logic stack_done;
    logic [7:0] popped_cc;
  } core_evt_type;

  typedef struct packed {
    logic stack_req;
    logic vec_load;
    logic [15:0] vec_addr;
  } core_entry_type;

  // larger rank means higher software priority
  function automatic logic [1:0] lvl_rank(input logic [1:0] l);
    logic [1:0] r;
    r = 2'h0;
    unique case (l)
      LVL0: r = 2'h0;
      LVL1: r = 2'h1;
      LVL2: r = 2'h2;
      LVL3: r = 2'h3;
    endcase
    return r;
  endfunction
endpackage

// File: verilog/nested_priority_interrupt_control.sv
/*
  nested interrupt controller: latches requests, arbitrates by software
  then hardware priority, drives the core's entry sequence and level bits.
  assumes the core pulses its events on mclk, holds off the next
  instruction while stack_req or vec_load is high, and answers stacking
  with stack_done. external pins are asynchronous; peripheral inputs are not.
*/
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
module nested_priority_interrupt_control
  import irq_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire core_evt_type core_evt,
  output core_entry_type core_entry,
  output logic [1:0] cur_level,
  output logic [7:0] cc_level_bits,
  output logic core_asleep,
  input wire logic [NVEC-1:0] periph_flag,
  input wire logic [NVEC-1:0] periph_ien,
  input wire logic [NVEC-1:0] periph_clear,
  input wire logic [NEXT*EXT_PINS-1:0] ext_pins
);

  ctl_state_type state_r;
  ctl_state_type state_nxt;
  logic [1:0] lvl_r;
  logic [1:0] lvl_nxt;
  logic [1:0] prio_r [NVEC];
  logic [2*NVEC-1:0] prio_flat;
  logic [31:0] prio_ext;
  logic [NVEC-1:0] irq_en_r;
  logic [NEXT*EXT_PINS-1:0] ext_sel_r;
  logic [NEXT-1:0] ext_edge_r;
  logic [NEXT*EXT_PINS-1:0] ext_s1_r;
  logic [NEXT*EXT_PINS-1:0] ext_s2_r;
  logic [NEXT*EXT_PINS-1:0] ext_s3_r;
  logic [NEXT-1:0] line_req;
  logic [NVEC-1:0] src_req;
  logic [NVEC-1:0] pend_r;
  logic [NVEC-1:0] pend_nxt;
  logic [NVEC-1:0] entry_clr;
  logic [NVEC-1:0] eligible;
  logic best_found;
  logic [3:0] best_idx;
  logic [1:0] best_rank;
  logic [15:0] sel_vec_r;
  logic [1:0] sel_lvl_r;
  logic [3:0] sel_idx_r;
  logic sel_nmi_r;
  logic halt_first_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  wire in_run = state_r == ST_RUN;
  wire take_trap = in_run && core_evt.trap;
  wire take_irq = in_run && core_evt.instr_end && best_found && !core_evt.trap;
  wire wake_any = |(pend_r & irq_en_r);
  wire wake_halt = |(pend_r & irq_en_r & HALT_WAKE);
  wire [1:0] cur_rank = lvl_rank(lvl_r);
  wire [1:0] popped_lvl = {core_evt.popped_cc[CC_HI_POS], core_evt.popped_cc[CC_LO_POS]};

  // apb decode
  wire setup = psel && !penable;
  wire acc_wr = psel && penable && pwrite;
  wire prio_hit = paddr[11:4] == ADDR_PRIO_BASE[11:4] && paddr[1:0] == 2'h0;
  wire [1:0] prio_sel = paddr[3:2];
  wire en_hit = paddr == ADDR_IRQ_EN;
  wire sel_hit = paddr == ADDR_EXT_SEL;
  wire edge_hit = paddr == ADDR_EXT_EDGE;
  wire stat_hit = paddr == ADDR_STATUS;
  wire mapped = prio_hit || en_hit || sel_hit || edge_hit || stat_hit;
  wire [31:0] rd_val =
    prio_hit ? {24'h00_0000, prio_ext[{prio_sel, 3'h0} +: 8]} :
    en_hit ? {19'h0_0000, irq_en_r} :
    sel_hit ? {20'h0_0000, ext_sel_r} :
    edge_hit ? {29'h0000_0000, ext_edge_r} :
    stat_hit ? {14'h0000, pend_r, lvl_r, state_r} :
    32'h0000_0000;

  assign pready = psel && penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  // upper fields of the last priority register read as ones
  assign prio_ext = {PRIO_PAD, prio_flat};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= !mapped;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_en_r <= IRQ_EN_RST;
      ext_sel_r <= EXT_SEL_RST;
      ext_edge_r <= EXT_EDGE_RST;
    end else if (acc_wr) begin
      if (en_hit) irq_en_r <= pwdata[NVEC-1:0];
      if (sel_hit) ext_sel_r <= pwdata[NEXT*EXT_PINS-1:0];
      if (edge_hit) ext_edge_r <= pwdata[NEXT-1:0];
    end
  end

  // pins are asynchronous: two stages before any logic, a third for edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_s3_r <= '0;
    end else begin
      ext_s1_r <= ext_pins;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  genvar k;
  generate
    for (k = 0; k < NEXT; k++) begin : g_line
      wire [EXT_PINS-1:0] lvl_now = ext_s2_r[k*EXT_PINS +: EXT_PINS];
      wire [EXT_PINS-1:0] lvl_old = ext_s3_r[k*EXT_PINS +: EXT_PINS];
      wire [EXT_PINS-1:0] act = ext_edge_r[k] ? (lvl_now & ~lvl_old) : lvl_now;
      assign line_req[k] = |(ext_sel_r[k*EXT_PINS +: EXT_PINS] & act);
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < NVEC; i++) begin : g_vec
      localparam int REG = i / 4;
      localparam int FLD = i % 4;
      wire [1:0] wr_val = pwdata[2*FLD +: 2];
      wire wr_fld = acc_wr && prio_hit && prio_sel == 2'(REG) && wr_val != LVL0;
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) prio_r[i] <= PRIO_RST;
        else if (wr_fld) prio_r[i] <= wr_val;
      end
      assign prio_flat[2*i +: 2] = prio_r[i];
      if (i >= EXT_BASE && i < EXT_BASE + NEXT) begin : g_ext
        assign src_req[i] = line_req[i-EXT_BASE];
      end else begin : g_per
        assign src_req[i] = periph_flag[i] && periph_ien[i];
      end
      // a request must beat the running level and, right after halt, be halt-capable
      assign eligible[i] = pend_r[i] && irq_en_r[i] && lvl_rank(prio_r[i]) > cur_rank
                           && (!halt_first_r || HALT_WAKE[i]);
    end
  endgenerate

  // a new request in the clearing cycle survives: set wins over clear
  assign entry_clr = (state_r == ST_VECTOR && !sel_nmi_r) ?
                     ({{(NVEC-1){1'b0}}, 1'b1} << sel_idx_r) : '0;
  assign pend_nxt = (pend_r & ~(periph_clear | entry_clr)) | src_req;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) pend_r <= '0;
    else pend_r <= pend_nxt;
  end

  // scan downward so that on equal rank the lower index (higher address) wins
  always_comb begin
    best_found = 1'b0;
    best_idx = 4'h0;
    best_rank = 2'h0;
    for (int v = NVEC - 1; v >= 0; v--) begin
      if (eligible[v] && (!best_found || lvl_rank(prio_r[v]) >= best_rank)) begin
        best_found = 1'b1;
        best_idx = 4'(v);
        best_rank = lvl_rank(prio_r[v]);
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (take_trap || take_irq) state_nxt = ST_STACK;
        else if (core_evt.halt) state_nxt = ST_HALT;
        else if (core_evt.wait_for_irq_instr) state_nxt = ST_WAIT;
      end
      ST_STACK: if (core_evt.stack_done) state_nxt = ST_VECTOR;
      ST_VECTOR: state_nxt = ST_RUN;
      ST_WAIT: if (wake_any) state_nxt = ST_RUN;
      ST_HALT: if (wake_halt) state_nxt = ST_RUN;
    endcase
  end

  // reset itself is the first entry: vector state with the reset vector, no stacking
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) state_r <= ST_VECTOR;
    else state_r <= state_nxt;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_vec_r <= VEC_RESET;
      sel_lvl_r <= LVL3;
      sel_idx_r <= 4'h0;
      sel_nmi_r <= 1'b1;
    end else if (take_trap) begin
      sel_vec_r <= VEC_TRAP;
      sel_lvl_r <= LVL3;
      sel_nmi_r <= 1'b1;
    end else if (take_irq) begin
      sel_vec_r <= VEC_BASE - {11'h000, best_idx, 1'b0};
      sel_lvl_r <= prio_r[best_idx];
      sel_idx_r <= best_idx;
      sel_nmi_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) halt_first_r <= 1'b0;
    else if (state_r == ST_HALT && wake_halt) halt_first_r <= 1'b1;
    else if (state_r == ST_VECTOR) halt_first_r <= 1'b0;
  end

  // level bits: entry, return and the dedicated instructions
  assign lvl_nxt =
    (state_r == ST_VECTOR) ? sel_lvl_r :
    !in_run ? lvl_r :
    core_evt.interrupt_return_instr ? popped_lvl :
    core_evt.sim ? LVL3 :
    (core_evt.irq_enable_instr || core_evt.halt || core_evt.wait_for_irq_instr) ? LVL0 :
    lvl_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) lvl_r <= LVL3;
    else lvl_r <= lvl_nxt;
  end

  assign cur_level = lvl_r;
  assign cc_level_bits = {2'h0, lvl_r[1], 1'b0, lvl_r[0], 3'h0};
  assign core_asleep = state_r == ST_WAIT || state_r == ST_HALT;
  assign core_entry.stack_req = state_r == ST_STACK;
  assign core_entry.vec_load = state_r == ST_VECTOR;
  assign core_entry.vec_addr = sel_vec_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_vec_range: assert property (
    core_entry.vec_load |-> core_entry.vec_addr >= VEC_BOTTOM && !core_entry.vec_addr[0])
    else $error("vector address outside the vector table");

  chk_stack_then_vec: assert property (
    state_r == ST_STACK && core_evt.stack_done |=> core_entry.vec_load ##1 !core_entry.vec_load)
    else $error("vector load did not follow stacking");

  chk_nmi_level: assert property (
    core_entry.vec_load && sel_nmi_r |=> cur_level == LVL3)
    else $error("non-maskable entry did not set level 3");

  chk_entry_level: assert property (
    take_irq |=> core_entry.stack_req [*1] ##0 sel_lvl_r == $past(prio_r[best_idx])
      && lvl_rank(sel_lvl_r) > $past(cur_rank))
    else $error("entry level not above running level");

  chk_interrupt_return_instr_restore: assert property (
    in_run && core_evt.interrupt_return_instr |=> cur_level == $past(popped_lvl))
    else $error("return did not restore level bits");

  chk_rim_sim: assert property (
    in_run && !core_evt.interrupt_return_instr && core_evt.sim |=> cur_level == LVL3)
    else $error("disable instruction did not load level 3");

  chk_prio_keep: assert property (
    acc_wr && prio_hit && prio_sel == 2'h0 && pwdata[1:0] == LVL0 |=> $stable(prio_r[0]))
    else $error("level-0 write changed a priority field");

  chk_halt_hold: assert property (
    state_r == ST_HALT && !wake_halt |=> state_r == ST_HALT)
    else $error("halt ended without a halt-capable request");

  chk_trap_entry: assert property (
    take_trap |=> core_entry.stack_req && sel_vec_r == VEC_TRAP)
    else $error("trap did not start stacking");

  chk_hold_pending: assert property (
    pend_r[0] && !periph_clear[0] && !entry_clr[0] |=> pend_r[0])
    else $error("pending request lost");

endmodule // nested_priority_interrupt_control

// File: verif/core_model.sv
/*
  behavioural core beside the interrupt controller: ends instructions,
  answers stacking promptly or slowly, and forwards the bench's events.
  assumes the controller's entry handshake runs on mclk.
*/
`timescale 1ns/1ns
module core_model
  import irq_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic core_asleep,
  input wire core_entry_type core_entry,
  input wire core_evt_type ev_req,
  output core_evt_type core_evt
);
  logic [3:0] wait_r;
  logic [3:0] wait_nxt;
  logic done;
  assign wait_nxt = (core_entry.stack_req && wait_r != 4'hf) ? wait_r + 4'h1 : 4'h0;
  // a slow stack write stretches stacking, so entry must really wait for done
  assign done = core_entry.stack_req && (wait_r == (slow ? 4'h4 : 4'h1));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) wait_r <= 4'h0;
    else wait_r <= wait_nxt;
  end
  always_comb begin
    core_evt = ev_req;
    // no instruction ends while asleep or inside an entry sequence
    core_evt.instr_end = !core_asleep && !core_entry.stack_req && !core_entry.vec_load;
    core_evt.stack_done = done;
  end
endmodule // core_model

// File: verif/nested_priority_interrupt_control_tb_top.sv
/*
  self-checking bench of the nested interrupt controller over apb.
  assumes core_model answers the entry handshake; external pins drive only line 1, near the end.
*/
`timescale 1ns/1ns
module nested_priority_interrupt_control_tb_top;
  import irq_ctl_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  core_evt_type core_evt;
  core_evt_type ev_req = '0;
  core_entry_type core_entry;
  logic [1:0] cur_level;
  logic [7:0] cc_level_bits;
  logic core_asleep;
  logic slow = 1'b0;
  logic [NVEC-1:0] periph_flag = '0;
  logic [NVEC-1:0] periph_ien = '0;
  logic [NVEC-1:0] periph_clear = '0;
  logic [11:0] ext_pins = 12'h000;
  logic [1:0] exp_lvl;
  logic [31:0] rng = 32'h0a36_47a9;
  logic [31:0] rd;
  logic err;
  logic [1:0] exp_prio [NVEC];
  int fails = 0;
  int total_checks = 0;

  always #2 mclk = ~mclk;

  nested_priority_interrupt_control dut (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_evt(core_evt),
    .core_entry(core_entry), .cur_level(cur_level), .cc_level_bits(cc_level_bits), .core_asleep(core_asleep),
    .periph_flag(periph_flag), .periph_ien(periph_ien), .periph_clear(periph_clear), .ext_pins(ext_pins));
  core_model core (.mclk(mclk), .rstn(rstn), .slow(slow), .core_asleep(core_asleep), .core_entry(core_entry),
    .ev_req(ev_req), .core_evt(core_evt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] vaddr(input int v);
    return VEC_BASE - 16'(2 * v);
  endfunction
  function automatic logic [31:0] prio_word(input int r);
    logic [31:0] w;
    w = (r == 3) ? 32'h0000_00fc : 32'h0000_0000;
    for (int f = 0; f < 4; f++) if (4 * r + f < NVEC) w[2*f+:2] = exp_prio[4*r+f];
    return w;
  endfunction

  task print_verdict;
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task bound(input int n, input int lim);
    if (n >= lim) begin
      check(1'b0, "wait ran out");
      print_verdict;
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    int v;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bound(n, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      v = 4 * a[3:2] + f;
      if (w && a < ADDR_IRQ_EN && v < NVEC && d[2*f+:2] != LVL0) exp_prio[v] = d[2*f+:2];
    end
  endtask
  task pulse(input logic [15:0] e);
    @(posedge mclk);
    rng = xs(rng);
    slow <= rng[8];
    ev_req <= core_evt_type'(e);
    @(posedge mclk);
    ev_req <= '0;
    // one more edge so the new level is read from a settled register
    @(posedge mclk);
  endtask
  task entry(input logic [15:0] va, input logic [1:0] lvl);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (core_entry.vec_load !== 1'b1 && n < 60);
    bound(n, 60);
    check(core_entry.vec_addr === va, "vector address");
    @(posedge mclk);
    check(cur_level === lvl, "level on entry");
    check(cc_level_bits === {2'b00, lvl[1], 1'b0, lvl[0], 3'b000}, "cc level bits");
  endtask
  task idle(input int c, input string m);
    repeat (c) begin
      @(posedge mclk);
      check(core_entry.stack_req === 1'b0, m);
    end
  endtask

  initial begin
    for (int i = 0; i < NVEC; i++) exp_prio[i] = PRIO_RST;
    // the reset branch only runs once an edge arrives, as rstn starts low without an event
    @(posedge mclk);
    #1;
    check(core_entry.vec_load === 1'b1 && core_entry.vec_addr === VEC_RESET, "reset vector");
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    check(cur_level === LVL3 && core_entry.stack_req === 1'b0, "level after reset");
    for (int r = 0; r < 4; r++) begin
      apb(12'(4 * r), 1'b0, 32'h0000_0000);
      check(rd === prio_word(r), "priority reset value");
    end
    apb(12'h000, 1'b1, 32'h0000_00cf);
    apb(12'h000, 1'b1, 32'h0000_0064);
    apb(12'h000, 1'b0, 32'h0000_0000);
    check(rd === 32'h0000_0044, "level 0 code kept out");
    repeat (12) begin
      rng = xs(rng);
      apb({8'h00, rng[1:0], 2'b00}, 1'b1, rng);
      apb({8'h00, rng[1:0], 2'b00}, 1'b0, 32'h0000_0000);
      check(rd === prio_word(rng[1:0]), "priority readback");
    end
    apb(12'h040, 1'b0, 32'h0000_0000);
    check(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    apb(12'h004, 1'b1, 32'h0000_0017);
    apb(12'h008, 1'b1, 32'h0000_00df);
    apb(ADDR_IRQ_EN, 1'b1, 32'h0000_04e0);
    periph_ien <= '1;
    periph_flag <= 13'h00e1;
    idle(10, "entry at level 3");
    pulse(16'h1000);
    entry(vaddr(7), LVL2);
    idle(6, "entry below current level");
    periph_flag <= 13'h0060;
    periph_clear <= 13'h0080;
    @(posedge mclk);
    periph_clear <= '0;
    pulse(16'h2020);
    check(cur_level === LVL0, "return level");
    entry(vaddr(5), LVL1);
    periph_flag <= 13'h0000;
    periph_clear <= 13'h0060;
    @(posedge mclk);
    periph_clear <= '0;
    rng = xs(rng);
    exp_lvl = rng[1:0];
    pulse({8'h20, 2'b00, rng[1], 1'b0, rng[0], 3'b000});
    check(cur_level === exp_lvl, "random return level");
    idle(8, "cleared request serviced");
    pulse(16'h4000);
    entry(VEC_TRAP, LVL3);
    pulse(16'h0800);
    check(cur_level === LVL3, "disable level");
    pulse(16'h1000);
    check(cur_level === LVL0, "enable level");
    apb(12'h004, 1'b1, 32'h0000_001f);
    pulse(16'h0400);
    check(core_asleep === 1'b1 && cur_level === LVL0, "halt entered");
    periph_flag <= 13'h0020;
    idle(8, "halt left by non-wake source");
    check(core_asleep === 1'b1, "still halted");
    periph_flag <= 13'h0420;
    entry(vaddr(10), LVL1);
    entry(vaddr(5), LVL3);
    periph_flag <= '0;
    periph_clear <= 13'h0420;
    @(posedge mclk);
    periph_clear <= '0;
    apb(12'h000, 1'b1, 32'h0000_0056);
    apb(ADDR_EXT_SEL, 1'b1, 32'h0000_0060);
    apb(ADDR_EXT_EDGE, 1'b1, 32'h0000_0002);
    apb(ADDR_IRQ_EN, 1'b1, 32'h0000_0008);
    pulse(16'h2020);
    ext_pins <= 12'h040;
    entry(vaddr(3), LVL1);
    pulse(16'h2020);
    idle(8, "edge request kept after entry");
    pulse(16'h0200);
    check(core_asleep === 1'b1 && cur_level === LVL0, "wait entered");
    ext_pins <= 12'h060;
    entry(vaddr(3), LVL1);
    print_verdict;
  end
endmodule // nested_priority_interrupt_control_tb_top
